// ### pot_ctrl_pkg.sv
// Constants and types for the dual potentiometer instruction controller
package pot_ctrl_pkg;
   // Slave address upper nibble; value is arbitrary, not a real part code
   localparam logic [3:0] DEVICE_TYPE_ID = 4'hA;
   // Instruction opcodes
   localparam logic [3:0] OP_READ_WIPER = 4'h9;
   localparam logic [3:0] OP_WRITE_WIPER = 4'hA;
   localparam logic [3:0] OP_READ_STORED = 4'hB;
   localparam logic [3:0] OP_WRITE_STORED = 4'hC;
   localparam logic [3:0] OP_XFR_TO_WIPER = 4'hD;
   localparam logic [3:0] OP_XFR_TO_STORED = 4'hE;
   localparam logic [3:0] OP_GLOBAL_TO_WIPER = 4'h1;
   localparam logic [3:0] OP_GLOBAL_TO_STORED = 4'h8;
   localparam logic [3:0] OP_STEP = 4'h2;
   // Instruction field positions
   localparam int OPCODE_MSB = 7;
   localparam int OPCODE_LSB = 4;
   localparam int POT_SELECT_BIT = 2;
   localparam int REG_SELECT_MSB = 1;
   localparam int REG_SELECT_LSB = 0;
   // Widths and sizes
   localparam int WIPER_WIDTH = 6;
   localparam int STORED_WIDTH = 8;
   localparam int POT_COUNT = 2;
   localparam int REGS_PER_POT = 4;
   localparam int TAP_COUNT = 64;
   localparam logic [5:0] WIPER_MAX = 6'h3F;
   localparam logic [5:0] WIPER_MIN = 6'h00;
   // Reset values
   localparam logic [7:0] STORED_RESET = 8'h00;
   // Timing
   localparam int CLK_FREQ_HZ = 10_000_000;
   localparam int NV_WRITE_TIME_MS = 5;
   localparam int NV_WRITE_TIME_MAX_MS = 10;
   localparam int NV_WRITE_CYCLES =
      (CLK_FREQ_HZ / 1000) * NV_WRITE_TIME_MS;
   localparam int WIPER_SETTLE_DELAY_NS = 1000;
   localparam int WIPER_SETTLE_CYCLES =
      (WIPER_SETTLE_DELAY_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
   localparam int BYTE_BITS = 8;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_INSTR, ST_INSTR_ACK,
      ST_DATA_IN, ST_DATA_ACK, ST_DATA_OUT, ST_MASTER_ACK, ST_STEP,
      ST_IGNORE
   } ctrl_state_t;
endpackage : pot_ctrl_pkg

// ### bus_condition_detect.sv
// Start, stop and SCL edge detection on the synchronous bus inputs
`timescale 1ns/10ps
`default_nettype none
module bus_condition_detect (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   // Events
   output logic scl_rise,
   output logic scl_fall,
   output logic start_seen,
   output logic stop_seen,
   output logic sda_level
);
   logic scl_q;
   logic sda_q;
   logic next_scl_q;
   logic next_sda_q;

   always_comb begin
      next_scl_q = scl;
      next_sda_q = sda;
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= next_scl_q;
         sda_q <= next_sda_q;
      end
   end

   assign scl_rise = scl & ~scl_q;
   assign scl_fall = ~scl & scl_q;
   // SDA edges while SCL stays high mark frame boundaries
   assign start_seen = scl & scl_q & sda_q & ~sda;
   assign stop_seen = scl & scl_q & ~sda_q & sda;
   assign sda_level = sda;
endmodule : bus_condition_detect
`default_nettype wire

// ### dual_pot_instruction_control.sv
// Instruction decoder and register control for a dual 64-tap potentiometer
// Summary of operation
// - Stop after nonvolatile command starts timed write
// - No address acknowledge while write is busy
// - Second byte decoded: opcode high, selects low
// - Pot select bit 2, register select bits 1:0
// - Transfer instructions end after instruction byte
// - Data-to-wiper load shows after settle delay
// - Wiper-to-data transfer is a nonvolatile write
// - Register read/write uses three-byte sequence
// - Opcodes 1001/1010 read/write selected wiper
// - Opcodes 1011/1100 read/write selected data register
// - Opcodes 1101/1110 transfer between data and wiper
// - Opcode 0001 loads both wipers from data
// - Opcode 1000 stores both wipers to data
// - Opcode 0010 enables stepping selected wiper
// - SCL pulse steps up if SDA high
// - Wiper is 6-bit counter, one-hot tap
// - Reset loads each wiper from register zero
// - Four nonvolatile registers per pot, bounded write
// - Acknowledge address, instruction and data bytes
// - Address must match type and address pins
`timescale 1ns/10ps
`default_nettype none
module dual_pot_instruction_control #(
   parameter int NV_WRITE_CYCLES = pot_ctrl_pkg::NV_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Serial bus
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Address straps
   input wire logic [3:0] address_pins,
   // Wiper tap selects, one-hot per pot
   output logic [63:0] tap_select_0,
   output logic [63:0] tap_select_1,
   // Status
   output logic nv_write_busy
);
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic sda_level;

   bus_condition_detect u_detect (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .scl(scl),
      .sda(sda_in),
      .scl_rise(scl_rise),
      .scl_fall(scl_fall),
      .start_seen(start_seen),
      .stop_seen(stop_seen),
      .sda_level(sda_level)
   );

   pot_ctrl_pkg::ctrl_state_t state;
   pot_ctrl_pkg::ctrl_state_t next_state;
   logic [7:0] shift;
   logic [7:0] next_shift;
   logic [3:0] bit_count;
   logic [3:0] next_bit_count;
   logic [7:0] instr;
   logic [7:0] next_instr;
   logic drive_low;
   logic next_drive_low;
   logic [7:0] stored [0:7];
   logic [7:0] next_stored [0:7];
   logic [5:0] wiper [0:1];
   logic [5:0] next_wiper [0:1];
   logic [5:0] shown [0:1];
   logic [5:0] next_shown [0:1];
   logic [1:0] settle_pending;
   logic [1:0] next_settle_pending;
   logic [7:0] settle_count;
   logic [7:0] next_settle_count;
   logic [23:0] nv_count;
   logic [23:0] next_nv_count;
   logic nv_pending;
   logic next_nv_pending;
   logic init_done;
   logic next_init_done;

   logic [3:0] opcode;
   logic pot;
   logic [1:0] rsel;
   logic [2:0] sel_index;
   logic addr_match;

   assign opcode = instr[pot_ctrl_pkg::OPCODE_MSB:pot_ctrl_pkg::OPCODE_LSB];
   assign pot = instr[pot_ctrl_pkg::POT_SELECT_BIT];
   assign rsel = instr[pot_ctrl_pkg::REG_SELECT_MSB:
                       pot_ctrl_pkg::REG_SELECT_LSB];
   assign sel_index = {pot, rsel};
   // Full compare of type nibble and straps before any acknowledge
   assign addr_match = (shift[7:4] == pot_ctrl_pkg::DEVICE_TYPE_ID) &&
                       (shift[3:0] == address_pins);

   always_comb begin
      next_state = state;
      next_shift = shift;
      next_bit_count = bit_count;
      next_instr = instr;
      next_drive_low = drive_low;
      for (int i = 0; i < 8; i++) begin
         next_stored[i] = stored[i];
      end
      for (int p = 0; p < 2; p++) begin
         next_wiper[p] = wiper[p];
         next_shown[p] = shown[p];
      end
      next_settle_pending = settle_pending;
      next_settle_count = settle_count;
      next_nv_count = nv_count;
      next_nv_pending = nv_pending;
      next_init_done = 1'b1;

      // Power-up load from register zero of each pot
      if (!init_done) begin
         next_wiper[0] = stored[0][5:0];
         next_wiper[1] = stored[4][5:0];
         next_shown[0] = stored[0][5:0];
         next_shown[1] = stored[4][5:0];
      end

      // Parallel loads reach the taps only after the settle delay
      if (settle_pending != 2'b00 && bit_count != 4'hE) begin
         if (settle_count == 8'h00) begin
            for (int p = 0; p < 2; p++) begin
               if (settle_pending[p]) begin
                  next_shown[p] = wiper[p];
               end
            end
            next_settle_pending = 2'b00;
         end else begin
            next_settle_count = settle_count - 8'h01;
         end
      end

      // Write cycle timer; inputs ignored until it expires
      if (nv_write_busy) begin
         if (nv_count == 24'h000000) begin
            next_nv_pending = 1'b0;
         end else begin
            next_nv_count = nv_count - 24'h000001;
         end
      end

      if (nv_write_busy) begin
         next_state = pot_ctrl_pkg::ST_IGNORE;
         next_drive_low = 1'b0;
      end else if (stop_seen) begin
         next_state = pot_ctrl_pkg::ST_IDLE;
         next_drive_low = 1'b0;
         // Nonvolatile commands start the write timer at the stop
         if (state == pot_ctrl_pkg::ST_IDLE && bit_count == 4'hF) begin
            next_nv_pending = 1'b1;
            next_nv_count = 24'(NV_WRITE_CYCLES - 1);
         end
         // Settle delay runs from the stop, not from the acknowledge
         if (state == pot_ctrl_pkg::ST_IDLE && bit_count == 4'hE) begin
            next_settle_count =
               8'(pot_ctrl_pkg::WIPER_SETTLE_CYCLES - 1);
         end
         next_bit_count = 4'h0;
      end else if (start_seen) begin
         next_state = pot_ctrl_pkg::ST_ADDR;
         next_bit_count = 4'h0;
         next_drive_low = 1'b0;
      end else begin
         case (state)
            pot_ctrl_pkg::ST_IDLE, pot_ctrl_pkg::ST_IGNORE: begin
               next_drive_low = 1'b0;
               if (state == pot_ctrl_pkg::ST_IGNORE) begin
                  next_state = pot_ctrl_pkg::ST_IDLE;
               end
            end
            pot_ctrl_pkg::ST_ADDR, pot_ctrl_pkg::ST_INSTR,
            pot_ctrl_pkg::ST_DATA_IN: begin
               if (scl_rise) begin
                  next_shift = {shift[6:0], sda_level};
                  next_bit_count = bit_count + 4'h1;
               end
               if (scl_fall && bit_count == 4'(pot_ctrl_pkg::BYTE_BITS)) begin
                  next_bit_count = 4'h0;
                  if (state == pot_ctrl_pkg::ST_ADDR) begin
                     if (addr_match) begin
                        next_drive_low = 1'b1;
                        next_state = pot_ctrl_pkg::ST_ADDR_ACK;
                     end else begin
                        next_state = pot_ctrl_pkg::ST_IGNORE;
                     end
                  end else if (state == pot_ctrl_pkg::ST_INSTR) begin
                     next_instr = shift;
                     next_drive_low = 1'b1;
                     next_state = pot_ctrl_pkg::ST_INSTR_ACK;
                  end else begin
                     next_drive_low = 1'b1;
                     next_state = pot_ctrl_pkg::ST_DATA_ACK;
                     if (opcode == pot_ctrl_pkg::OP_WRITE_WIPER) begin
                        next_wiper[pot] = shift[5:0];
                        next_shown[pot] = shift[5:0];
                     end else begin
                        next_stored[sel_index] = shift;
                     end
                  end
               end
            end
            pot_ctrl_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  next_drive_low = 1'b0;
                  next_state = pot_ctrl_pkg::ST_INSTR;
               end
            end
            pot_ctrl_pkg::ST_INSTR_ACK: begin
               if (scl_fall) begin
                  next_drive_low = 1'b0;
                  next_state = pot_ctrl_pkg::ST_IDLE;
                  next_bit_count = 4'h0;
                  case (opcode)
                     // First data bit goes out on the fall ending the ack
                     pot_ctrl_pkg::OP_READ_WIPER: begin
                        next_drive_low = 1'b1;
                        next_shift = {1'b0, wiper[pot], 1'b0};
                        next_bit_count = 4'h1;
                        next_state = pot_ctrl_pkg::ST_DATA_OUT;
                     end
                     pot_ctrl_pkg::OP_READ_STORED: begin
                        next_drive_low = ~stored[sel_index][7];
                        next_shift = {stored[sel_index][6:0], 1'b0};
                        next_bit_count = 4'h1;
                        next_state = pot_ctrl_pkg::ST_DATA_OUT;
                     end
                     pot_ctrl_pkg::OP_WRITE_WIPER,
                     pot_ctrl_pkg::OP_WRITE_STORED: begin
                        next_state = pot_ctrl_pkg::ST_DATA_IN;
                     end
                     pot_ctrl_pkg::OP_XFR_TO_WIPER: begin
                        next_wiper[pot] = stored[sel_index][5:0];
                        next_settle_pending[pot] = 1'b1;
                        next_settle_count =
                           8'(pot_ctrl_pkg::WIPER_SETTLE_CYCLES - 1);
                        next_bit_count = 4'hE;
                     end
                     pot_ctrl_pkg::OP_GLOBAL_TO_WIPER: begin
                        next_wiper[0] = stored[{1'b0, rsel}][5:0];
                        next_wiper[1] = stored[{1'b1, rsel}][5:0];
                        next_settle_pending = 2'b11;
                        next_settle_count =
                           8'(pot_ctrl_pkg::WIPER_SETTLE_CYCLES - 1);
                        next_bit_count = 4'hE;
                     end
                     pot_ctrl_pkg::OP_XFR_TO_STORED: begin
                        next_stored[sel_index] = {2'b00, wiper[pot]};
                        next_bit_count = 4'hF;
                     end
                     pot_ctrl_pkg::OP_GLOBAL_TO_STORED: begin
                        next_stored[{1'b0, rsel}] = {2'b00, wiper[0]};
                        next_stored[{1'b1, rsel}] = {2'b00, wiper[1]};
                        next_bit_count = 4'hF;
                     end
                     pot_ctrl_pkg::OP_STEP: begin
                        next_state = pot_ctrl_pkg::ST_STEP;
                     end
                     default: begin
                        next_state = pot_ctrl_pkg::ST_IGNORE;
                     end
                  endcase
               end
            end
            pot_ctrl_pkg::ST_DATA_ACK: begin
               if (scl_fall) begin
                  next_drive_low = 1'b0;
                  next_state = pot_ctrl_pkg::ST_IDLE;
                  // Only a data register write needs the write cycle
                  next_bit_count =
                     (opcode == pot_ctrl_pkg::OP_WRITE_STORED) ? 4'hF : 4'h0;
               end
            end
            pot_ctrl_pkg::ST_DATA_OUT: begin
               if (scl_fall) begin
                  if (bit_count == 4'(pot_ctrl_pkg::BYTE_BITS)) begin
                     next_drive_low = 1'b0;
                     next_state = pot_ctrl_pkg::ST_MASTER_ACK;
                  end else begin
                     next_drive_low = ~shift[7];
                     next_shift = {shift[6:0], 1'b0};
                     next_bit_count = bit_count + 4'h1;
                  end
               end
            end
            pot_ctrl_pkg::ST_MASTER_ACK: begin
               if (scl_fall) begin
                  next_state = pot_ctrl_pkg::ST_IGNORE;
               end
            end
            pot_ctrl_pkg::ST_STEP: begin
               // Saturate at the ends instead of wrapping
               if (scl_rise) begin
                  if (sda_level && wiper[pot] != pot_ctrl_pkg::WIPER_MAX) begin
                     next_wiper[pot] = wiper[pot] + 6'h01;
                     next_shown[pot] = wiper[pot] + 6'h01;
                  end else if (!sda_level &&
                               wiper[pot] != pot_ctrl_pkg::WIPER_MIN) begin
                     next_wiper[pot] = wiper[pot] - 6'h01;
                     next_shown[pot] = wiper[pot] - 6'h01;
                  end
               end
            end
            default: begin
               next_state = pot_ctrl_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= pot_ctrl_pkg::ST_IDLE;
         shift <= 8'h00;
         bit_count <= 4'h0;
         instr <= 8'h00;
         drive_low <= 1'b0;
         for (int i = 0; i < 8; i++) begin
            // Flops stand in for the nonvolatile cells in this model
            stored[i] <= pot_ctrl_pkg::STORED_RESET;
         end
         for (int p = 0; p < 2; p++) begin
            wiper[p] <= pot_ctrl_pkg::WIPER_MIN;
            shown[p] <= pot_ctrl_pkg::WIPER_MIN;
         end
         settle_pending <= 2'b00;
         settle_count <= 8'h00;
         nv_count <= 24'h000000;
         nv_pending <= 1'b0;
         init_done <= 1'b0;
      end else begin
         state <= next_state;
         shift <= next_shift;
         bit_count <= next_bit_count;
         instr <= next_instr;
         drive_low <= next_drive_low;
         for (int i = 0; i < 8; i++) begin
            stored[i] <= next_stored[i];
         end
         for (int p = 0; p < 2; p++) begin
            wiper[p] <= next_wiper[p];
            shown[p] <= next_shown[p];
         end
         settle_pending <= next_settle_pending;
         settle_count <= next_settle_count;
         nv_count <= next_nv_count;
         nv_pending <= next_nv_pending;
         init_done <= next_init_done;
      end
   end

   assign nv_write_busy = nv_pending;
   assign sda_out = 1'b0;
   assign sda_oe = drive_low;

   // One switch closed per pot
   genvar t;
   generate
      for (t = 0; t < pot_ctrl_pkg::TAP_COUNT; t++) begin : g_tap
         assign tap_select_0[t] = (shown[0] == 6'(t));
         assign tap_select_1[t] = (shown[1] == 6'(t));
      end
   endgenerate
endmodule : dual_pot_instruction_control
`default_nettype wire

// ### pot_ctrl_sva.sv
// Assertion checker bound to the potentiometer controller
`timescale 1ns/10ps
`default_nettype none
module pot_ctrl_sva #(
   parameter int NV_WRITE_CYCLES = pot_ctrl_pkg::NV_WRITE_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // Bus
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic [3:0] address_pins,
   // Taps and status
   input wire logic [63:0] tap_select_0,
   input wire logic [63:0] tap_select_1,
   input wire logic nv_write_busy
);
   int busy_len;
   int next_busy_len;
   always_comb begin
      next_busy_len = nv_write_busy ? busy_len + 1 : 0;
   end
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_len <= 0;
      end else begin
         busy_len <= next_busy_len;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   tap_zero_hot_a: assert property ($onehot(tap_select_0))
      else $error("tap 0 not one-hot");
   tap_one_hot_a: assert property ($onehot(tap_select_1))
      else $error("tap 1 not one-hot");
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("sda driven high");
   busy_no_ack_a: assert property (nv_write_busy |-> !sda_oe)
      else $error("ack while busy");
   busy_len_a: assert property ($fell(nv_write_busy) |->
      busy_len == NV_WRITE_CYCLES) else $error("busy length wrong");
   busy_bound_a: assert property (busy_len <= NV_WRITE_CYCLES + 1)
      else $error("busy too long");
   busy_on_stop_a: assert property ($rose(nv_write_busy) |->
      scl && sda_in) else $error("busy began without stop");
   ack_scl_low_a: assert property ($rose(sda_oe) |-> !scl)
      else $error("sda pulled while scl high");
   sda_steady_a: assert property (scl && $past(scl) |->
      $stable(sda_oe)) else $error("sda moved while scl high");
   taps_hold_a: assert property (nv_write_busy && $past(nv_write_busy)
      |-> $stable(tap_select_0) && $stable(tap_select_1))
      else $error("wiper moved while busy");
   cover property ($rose(nv_write_busy));
   cover property ($rose(sda_oe));
   cover property (tap_select_0[63]);
endmodule : pot_ctrl_sva
bind dual_pot_instruction_control pot_ctrl_sva #(
   .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) chk (.sys_clk, .reset_n, .scl, .sda_in, .sda_out, .sda_oe,
   .address_pins, .tap_select_0, .tap_select_1, .nv_write_busy);
`default_nettype wire

// ### two_wire_master.sv
// Behavioural two-wire bus master driving the controller
`timescale 1ns/10ps
`default_nettype none
module two_wire_master #(
   parameter int Q = 4
) (
   // Clock
   input wire logic sys_clk,
   // Bus
   output logic scl,
   output logic sda_low,
   input wire logic sda_line
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   // SDA only moves with SCL low, so data never looks like start or stop
   task automatic put_bit(input logic b);
      sda_low = !b;
      tick(Q);
      scl = 1'b1;
      tick(2 * Q);
      scl = 1'b0;
      tick(Q);
   endtask : put_bit
   task automatic get_bit(output logic b);
      sda_low = 1'b0;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      b = sda_line;
      tick(Q);
      scl = 1'b0;
      tick(Q);
   endtask : get_bit
   // Also serves as the poll start right after a stop
   task automatic start_cond;
      sda_low = 1'b0;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      sda_low = 1'b1;
      tick(Q);
      scl = 1'b0;
      tick(Q);
   endtask : start_cond
   task automatic stop_cond;
      sda_low = 1'b1;
      tick(Q);
      scl = 1'b1;
      tick(Q);
      sda_low = 1'b0;
      tick(2 * Q);
   endtask : stop_cond
   task automatic write_byte(input logic [7:0] d, output logic acked);
      logic b;
      for (int i = 7; i >= 0; i--)
         put_bit(d[i]);
      get_bit(b);
      acked = !b;
   endtask : write_byte
   task automatic read_byte(output logic [7:0] d, input logic ack);
      for (int i = 7; i >= 0; i--)
         get_bit(d[i]);
      put_bit(!ack);
   endtask : read_byte
endmodule : two_wire_master
`default_nettype wire

// ### testbench.sv
// Self-checking testbench for the potentiometer controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int NV = 200;
   localparam int LIMIT = 40000;
   localparam logic [3:0] ADDR = 4'h6;
   localparam logic [7:0] SLAVE = {pot_ctrl_pkg::DEVICE_TYPE_ID, ADDR};
   logic sys_clk;
   logic reset_n;
   logic scl;
   logic sda_low;
   logic sda_oe;
   logic sda_in;
   logic [3:0] address_pins;
   logic [63:0] tap0;
   logic [63:0] tap1;
   logic busy;
   int mismatches = 0;
   int n_checks = 0;
   int cycles = 0;
   // Pull-up on the shared open-drain line
   assign sda_in = !(sda_low || sda_oe);
   two_wire_master m (.sys_clk, .scl, .sda_low, .sda_line(sda_in));
   dual_pot_instruction_control #(.NV_WRITE_CYCLES(NV)) dut (.sys_clk,
      .reset_n, .scl, .sda_in, .sda_out(), .sda_oe, .address_pins,
      .tap_select_0(tap0), .tap_select_1(tap1), .nv_write_busy(busy));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         conclude;
      end
   end
   task automatic bad(input string s);
      mismatches++;
      $display("wrong value at %0t: %s", $time, s);
   endtask : bad
   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) bad($sformatf("bit %b not %b", got, exp));
   endtask : chk1
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) bad($sformatf("byte %h not %h", got, exp));
   endtask : chk8
   task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
      n_checks++;
      if (got !== exp) bad($sformatf("tap %h not %h", got, exp));
   endtask : chk64
   function automatic logic [63:0] tap(input logic [5:0] p);
      return 64'h1 << p;
   endfunction : tap
   function automatic logic [7:0] ins(input logic [3:0] op,
      input logic pot, input logic [1:0] rs);
      return {op, 1'b0, pot, rs};
   endfunction : ins
   task automatic open_cmd(input logic [7:0] instr);
      logic a;
      m.start_cond();
      m.write_byte(SLAVE, a);
      chk1(a, 1'b1);
      m.write_byte(instr, a);
      chk1(a, 1'b1);
   endtask : open_cmd
   task automatic close_cmd;
      m.stop_cond();
      m.tick(pot_ctrl_pkg::WIPER_SETTLE_CYCLES + 4);
   endtask : close_cmd
   task automatic wr(input logic [7:0] instr, input logic [7:0] d);
      logic a;
      open_cmd(instr);
      m.write_byte(d, a);
      chk1(a, 1'b1);
      close_cmd();
   endtask : wr
   task automatic rd(input logic [7:0] instr, output logic [7:0] d);
      open_cmd(instr);
      m.read_byte(d, 1'b0);
      close_cmd();
   endtask : rd
   // Stop after a nonvolatile command, then wait out the write
   task automatic nv_wait;
      int n;
      m.stop_cond();
      chk1(busy, 1'b1);
      n = 0;
      while (busy !== 1'b0 && n < 2 * NV) begin
         m.tick(1);
         n++;
      end
      chk1(busy, 1'b0);
   endtask : nv_wait
   task automatic t_reset;
      chk64(tap0, tap(6'h00));
      chk64(tap1, tap(6'h00));
      $display("test reset done");
   endtask : t_reset
   task automatic t_wiper;
      logic [7:0] d;
      wr(ins(pot_ctrl_pkg::OP_WRITE_WIPER, 1'b1, 2'h3), 8'hEA);
      chk64(tap1, tap(6'h2A));
      chk64(tap0, tap(6'h00));
      rd(ins(pot_ctrl_pkg::OP_READ_WIPER, 1'b1, 2'h1), d);
      chk8(d, 8'h2A);
      $display("test wiper done");
   endtask : t_wiper
   task automatic t_stored;
      logic a;
      logic [7:0] d;
      open_cmd(ins(pot_ctrl_pkg::OP_WRITE_STORED, 1'b0, 2'h2));
      m.write_byte(8'h15, a);
      m.stop_cond();
      m.start_cond();
      m.write_byte(SLAVE, a);
      chk1(a, 1'b0);
      nv_wait();
      m.start_cond();
      m.write_byte(SLAVE, a);
      chk1(a, 1'b1);
      m.stop_cond();
      rd(ins(pot_ctrl_pkg::OP_READ_STORED, 1'b0, 2'h2), d);
      chk8(d, 8'h15);
      rd(ins(pot_ctrl_pkg::OP_READ_STORED, 1'b0, 2'h1), d);
      chk8(d, 8'h00);
      $display("test stored done");
   endtask : t_stored
   task automatic t_xfr;
      logic [7:0] d;
      open_cmd(ins(pot_ctrl_pkg::OP_XFR_TO_WIPER, 1'b0, 2'h2));
      m.stop_cond();
      chk64(tap0, tap(6'h00));
      m.tick(pot_ctrl_pkg::WIPER_SETTLE_CYCLES + 4);
      chk64(tap0, tap(6'h15));
      open_cmd(ins(pot_ctrl_pkg::OP_XFR_TO_STORED, 1'b1, 2'h1));
      nv_wait();
      rd(ins(pot_ctrl_pkg::OP_READ_STORED, 1'b1, 2'h1), d);
      chk8(d, 8'h2A);
      $display("test transfer done");
   endtask : t_xfr
   task automatic t_global;
      logic [7:0] d;
      open_cmd({pot_ctrl_pkg::OP_GLOBAL_TO_STORED, 4'h7});
      nv_wait();
      rd(ins(pot_ctrl_pkg::OP_READ_STORED, 1'b0, 2'h3), d);
      chk8(d, 8'h15);
      rd(ins(pot_ctrl_pkg::OP_READ_STORED, 1'b1, 2'h3), d);
      chk8(d, 8'h2A);
      wr(ins(pot_ctrl_pkg::OP_WRITE_WIPER, 1'b0, 2'h0), 8'h00);
      wr(ins(pot_ctrl_pkg::OP_WRITE_WIPER, 1'b1, 2'h0), 8'h00);
      open_cmd({pot_ctrl_pkg::OP_GLOBAL_TO_WIPER, 4'hF});
      close_cmd();
      chk64(tap0, tap(6'h15));
      chk64(tap1, tap(6'h2A));
      $display("test global done");
   endtask : t_global
   task automatic t_step;
      wr(ins(pot_ctrl_pkg::OP_WRITE_WIPER, 1'b1, 2'h0), 8'h00);
      open_cmd(ins(pot_ctrl_pkg::OP_STEP, 1'b1, 2'h0));
      repeat (3) m.put_bit(1'b1);
      m.tick(pot_ctrl_pkg::WIPER_SETTLE_CYCLES + 4);
      chk64(tap1, tap(6'h03));
      repeat (5) m.put_bit(1'b0);
      m.tick(pot_ctrl_pkg::WIPER_SETTLE_CYCLES + 4);
      chk64(tap1, tap(6'h00));
      close_cmd();
      wr(ins(pot_ctrl_pkg::OP_WRITE_WIPER, 1'b0, 2'h0), 8'h3E);
      chk64(tap0, tap(6'h3E));
      open_cmd(ins(pot_ctrl_pkg::OP_STEP, 1'b0, 2'h0));
      repeat (3) m.put_bit(1'b1);
      m.tick(pot_ctrl_pkg::WIPER_SETTLE_CYCLES + 4);
      chk64(tap0, tap(6'h3F));
      chk64(tap1, tap(6'h00));
      close_cmd();
      $display("test step done");
   endtask : t_step
   task automatic t_address;
      logic a;
      m.start_cond();
      m.write_byte(SLAVE ^ 8'h01, a);
      chk1(a, 1'b0);
      m.stop_cond();
      m.start_cond();
      m.write_byte(SLAVE ^ 8'h80, a);
      chk1(a, 1'b0);
      m.stop_cond();
      address_pins = 4'h9;
      m.start_cond();
      m.write_byte({pot_ctrl_pkg::DEVICE_TYPE_ID, 4'h9}, a);
      chk1(a, 1'b1);
      m.stop_cond();
      address_pins = ADDR;
      $display("test address done");
   endtask : t_address
   initial begin
      reset_n = 1'b0;
      address_pins = ADDR;
      repeat (16) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      m.tick(4);
      t_reset();
      t_wiper();
      t_stored();
      t_xfr();
      t_global();
      t_step();
      t_address();
      conclude();
   end
endmodule : testbench
`default_nettype wire
